// ### src/dpb_defs.svh
// Purpose: shared constants for the two-word burst sram link
// Assumes: both ends run on a 125 MHz system clock
// Notes:   the link clocks are sampled, never used as clocks
`ifndef DPB_DEFS_SVH
`define DPB_DEFS_SVH
`define DPB_WIDTH_DEF     18
`define DPB_ADDR_DEF      10
`define DPB_LANE_DEF      2
`define DPB_CLK_DIV       4'h8
`define DPB_CLK_HALF      4'h4
`define DPB_SYNC_STAGES   2
`endif

// ### src/dpb_pkg.sv
// Purpose: shared types for the two-word burst sram link
// Assumes: nothing beyond the defs header
// Notes:   only the controller sequence state lives here
package dpb_pkg;
   typedef enum logic [1:0] {
      DPB_IDLE,
      DPB_HIGH,
      DPB_LOW
   } dpb_phase_t;
endpackage : dpb_pkg

// ### src/dpb_if.sv
// Purpose: pin bundle between the memory controller and the sram device
// Assumes: all pins are one-way; no tristate resolution is needed here
// Notes:   read data carries a separate drive enable
`timescale 1ns/1ns
`include "dpb_defs.svh"
interface dpb_if #(
   parameter int W = `DPB_WIDTH_DEF,
   parameter int A = `DPB_ADDR_DEF,
   parameter int L = `DPB_LANE_DEF
);
   logic           in_edge_pos;
   logic           in_edge_neg;
   logic           out_edge_pos;
   logic           out_edge_neg;
   logic           fetch_go_n;
   logic           store_go_n;
   logic [A-1:0]   addr;
   logic [L-1:0]   lane_mask_n;
   logic [W-1:0]   wr_beat_in;
   logic [W-1:0]   rd_beat_out;
   logic           rd_beat_oe;
   logic           return_strobe_pos;
   logic           return_strobe_neg;
   logic           phase_loop_off_n;
   modport ctrl (
      output in_edge_pos, in_edge_neg, out_edge_pos, out_edge_neg,
      output fetch_go_n, store_go_n, addr, lane_mask_n, wr_beat_in,
      output phase_loop_off_n,
      input  rd_beat_out, rd_beat_oe, return_strobe_pos, return_strobe_neg
   );
   modport dev (
      input  in_edge_pos, in_edge_neg, out_edge_pos, out_edge_neg,
      input  fetch_go_n, store_go_n, addr, lane_mask_n, wr_beat_in,
      input  phase_loop_off_n,
      output rd_beat_out, rd_beat_oe, return_strobe_pos, return_strobe_neg
   );
endinterface : dpb_if

// ### src/dpb_device.sv
// Purpose: sram device end of the two-word burst link
// Assumes: link clocks are much slower than clk and are sampled
// Notes:   array is small and parameterised; no reset of contents
`timescale 1ns/1ns
`include "dpb_defs.svh"

module dpb_device #(
   parameter int W = `DPB_WIDTH_DEF,
   parameter int A = `DPB_ADDR_DEF,
   parameter int L = `DPB_LANE_DEF
) (
   input  wire logic  clk,
   input  wire logic  reset_n,
   input  wire logic  clk_en,
   dpb_if.dev         pins,
   output logic       loop_bypass
);
   localparam int LW = W / L;
   localparam int S  = 7;
   // sync pipes: bit order pos, neg, opos, oneg, fetch, store, loopoff
   logic [S-1:0]   s1_ff, s2_ff, s3_ff;
   logic [A-1:0]   a1_ff, a2_ff;
   logic [L-1:0]   m1_ff, m2_ff;
   logic [W-1:0]   d1_ff, d2_ff;
   logic [W-1:0]   mem [0:(1<<A)-1];
   logic           wr_pend_ff, nxt_wr_pend;
   logic [A-1:0]   wr_addr_ff, nxt_wr_addr;
   logic [W-1:0]   wr_d0_ff, nxt_wr_d0;
   logic [L-1:0]   wr_m0_ff, nxt_wr_m0;
   logic           rd_pend_ff, nxt_rd_pend;
   logic [A-1:0]   rd_pend_addr_ff, nxt_rd_pend_addr;
   logic           rd_next_ff, nxt_rd_next;
   logic [A-1:0]   rd_next_addr_ff, nxt_rd_next_addr;
   logic           rd_sec_ff, nxt_rd_sec;
   logic [A-1:0]   rd_sec_addr_ff, nxt_rd_sec_addr;
   logic [W-1:0]   rd_q_ff, nxt_rd_q;
   logic           rd_oe_ff, nxt_rd_oe;
   logic           cq_ff, nxt_cq;
   logic           bypass_ff;
   logic           we0, we1;
   logic [A-1:0]   we_addr;
   logic [W-1:0]   we_data;
   logic [L-1:0]   we_mask;

   function automatic logic rise(input logic now, input logic old);
      rise = now & ~old;
   endfunction : rise

   wire logic [S-1:0] pin_raw = {pins.phase_loop_off_n, pins.store_go_n,
      pins.fetch_go_n, pins.out_edge_neg, pins.out_edge_pos,
      pins.in_edge_neg, pins.in_edge_pos};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_ff <= 7'h7F;
         s2_ff <= 7'h7F;
         s3_ff <= 7'h7F;
         a1_ff <= '0;
         a2_ff <= '0;
         m1_ff <= '1;
         m2_ff <= '1;
         d1_ff <= '0;
         d2_ff <= '0;
      end else if (clk_en) begin
         s1_ff <= pin_raw;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         a1_ff <= pins.addr;
         a2_ff <= a1_ff;
         m1_ff <= pins.lane_mask_n;
         m2_ff <= m1_ff;
         d1_ff <= pins.wr_beat_in;
         d2_ff <= d1_ff;
      end
   end

   wire logic k_up   = rise(s2_ff[0], s3_ff[0]);
   wire logic kn_up  = rise(s2_ff[1], s3_ff[1]);
   // both output clocks high falls back to the input pair
   wire logic use_k  = s2_ff[2] & s2_ff[3];
   wire logic c_up   = use_k ? k_up  : rise(s2_ff[2], s3_ff[2]);
   wire logic cn_up  = use_k ? kn_up : rise(s2_ff[3], s3_ff[3]);
   wire logic rd_go  = k_up & ~s2_ff[4];
   wire logic wr_go  = k_up & ~s2_ff[5];

   always_comb begin
      nxt_wr_pend = wr_pend_ff;
      nxt_wr_addr = wr_addr_ff;
      nxt_wr_d0   = wr_d0_ff;
      nxt_wr_m0   = wr_m0_ff;
      we0 = 1'b0;
      we1 = 1'b0;
      if (wr_go) begin
         nxt_wr_pend = 1'b1;
         nxt_wr_d0   = d2_ff;
         nxt_wr_m0   = m2_ff;
      end else if (wr_pend_ff && kn_up) begin
         // address is only looked at for a selected write
         nxt_wr_addr = a2_ff;
         nxt_wr_pend = 1'b0;
         we0 = 1'b1;
         we1 = 1'b1;
      end
   end

   assign we_addr = nxt_wr_addr;

   // both words of a burst land in one wide cycle; word 1 at addr+1
   always_ff @(posedge clk) begin
      if (clk_en && we0) begin
         for (int i = 0; i < L; i++) begin
            if (!wr_m0_ff[i])
               mem[we_addr][i*LW +: LW] <= wr_d0_ff[i*LW +: LW];
            if (!m2_ff[i])
               mem[A'(we_addr + 1'b1)][i*LW +: LW] <= d2_ff[i*LW +: LW];
         end
      end
   end

   always_comb begin
      nxt_rd_pend      = rd_pend_ff;
      nxt_rd_pend_addr = rd_pend_addr_ff;
      nxt_rd_next      = rd_next_ff;
      nxt_rd_next_addr = rd_next_addr_ff;
      nxt_rd_sec       = rd_sec_ff;
      nxt_rd_sec_addr  = rd_sec_addr_ff;
      nxt_rd_q         = rd_q_ff;
      nxt_rd_oe        = rd_oe_ff;
      // a read skips one inverted edge, so back-to-back reads overlap
      if (cn_up) begin
         nxt_rd_next      = rd_pend_ff;
         nxt_rd_next_addr = rd_pend_addr_ff;
         nxt_rd_pend      = 1'b0;
         nxt_rd_sec       = rd_next_ff;
         nxt_rd_sec_addr  = rd_next_addr_ff;
         nxt_rd_oe        = rd_next_ff;
         if (rd_next_ff)
            nxt_rd_q = mem[rd_next_addr_ff];
      end else if (c_up && rd_sec_ff) begin
         nxt_rd_q   = mem[A'(rd_sec_addr_ff + 1'b1)];
         nxt_rd_sec = 1'b0;
      end
      if (rd_go) begin
         nxt_rd_pend      = 1'b1;
         nxt_rd_pend_addr = a2_ff;
      end
      // echo strobe follows the active output reference, always running
      nxt_cq = cq_ff;
      if (c_up)
         nxt_cq = 1'b1;
      else if (cn_up)
         nxt_cq = 1'b0;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_pend_ff  <= 1'b0;
         wr_addr_ff  <= '0;
         wr_d0_ff    <= '0;
         wr_m0_ff    <= '1;
         rd_pend_ff      <= 1'b0;
         rd_pend_addr_ff <= '0;
         rd_next_ff      <= 1'b0;
         rd_next_addr_ff <= '0;
         rd_sec_ff       <= 1'b0;
         rd_sec_addr_ff  <= '0;
         rd_q_ff     <= '0;
         rd_oe_ff    <= 1'b0;
         cq_ff       <= 1'b0;
         bypass_ff   <= 1'b0;
      end else if (clk_en) begin
         wr_pend_ff  <= nxt_wr_pend;
         wr_addr_ff  <= nxt_wr_addr;
         wr_d0_ff    <= nxt_wr_d0;
         wr_m0_ff    <= nxt_wr_m0;
         rd_pend_ff      <= nxt_rd_pend;
         rd_pend_addr_ff <= nxt_rd_pend_addr;
         rd_next_ff      <= nxt_rd_next;
         rd_next_addr_ff <= nxt_rd_next_addr;
         rd_sec_ff       <= nxt_rd_sec;
         rd_sec_addr_ff  <= nxt_rd_sec_addr;
         rd_q_ff     <= nxt_rd_q;
         rd_oe_ff    <= nxt_rd_oe;
         cq_ff       <= nxt_cq;
         bypass_ff   <= ~s2_ff[6];
      end
   end

   assign pins.rd_beat_out       = rd_q_ff;
   assign pins.rd_beat_oe        = rd_oe_ff;
   assign pins.return_strobe_pos = cq_ff;
   assign pins.return_strobe_neg = ~cq_ff;
   assign loop_bypass            = bypass_ff;
endmodule : dpb_device

// ### src/dpb_ctrl.sv
// Purpose: memory controller end; makes the link clocks and bursts
// Assumes: user holds a request until its accept pulse
// Notes:   output clocks can be tied high to use the input pair
`timescale 1ns/1ns
`include "dpb_defs.svh"
module dpb_ctrl #(
   parameter int W = `DPB_WIDTH_DEF,
   parameter int A = `DPB_ADDR_DEF,
   parameter int L = `DPB_LANE_DEF
) (
   input  wire logic          clk,
   input  wire logic          reset_n,
   input  wire logic          clk_en,
   dpb_if.ctrl                pins,
   input  wire logic          tie_out_clk,
   input  wire logic          loop_off,
   input  wire logic          rd_req,
   input  wire logic          wr_req,
   input  wire logic [A-1:0]  req_addr,
   input  wire logic [W-1:0]  wr_word0,
   input  wire logic [W-1:0]  wr_word1,
   input  wire logic [L-1:0]  wr_mask0_n,
   input  wire logic [L-1:0]  wr_mask1_n,
   output logic               req_taken,
   output logic               rd_valid,
   output logic [W-1:0]       rd_word
);
   logic [3:0]     div_ff, nxt_div;
   dpb_pkg::dpb_phase_t ph_ff, nxt_ph;
   logic           rgo_ff, nxt_rgo, wgo_ff, nxt_wgo;
   logic [A-1:0]   addr_ff, nxt_addr;
   logic [W-1:0]   d_ff, nxt_d, d1_ff, nxt_d1;
   logic [L-1:0]   m_ff, nxt_m, m1_ff, nxt_m1;
   logic           taken_ff, nxt_taken;
   logic [2:0]     q1_ff, q2_ff;
   logic [1:0]     q3_ff;
   logic [W-1:0]   qd1_ff, qd2_ff;
   logic           vld_ff;
   logic [W-1:0]   rw_ff;
   logic           tie_ff;

   // link clocks by division; pos high in first half, neg is its inverse
   wire logic k_hi = (div_ff < `DPB_CLK_HALF);

   always_comb begin
      nxt_div   = (div_ff == `DPB_CLK_DIV - 4'h1) ? 4'h0 : div_ff + 4'h1;
      nxt_ph    = ph_ff;
      nxt_rgo   = rgo_ff;
      nxt_wgo   = wgo_ff;
      nxt_addr  = addr_ff;
      nxt_d     = d_ff;
      nxt_d1    = d1_ff;
      nxt_m     = m_ff;
      nxt_m1    = m1_ff;
      nxt_taken = 1'b0;
      case (ph_ff)
         dpb_pkg::DPB_IDLE: if (div_ff == `DPB_CLK_DIV - 4'h3) begin
            // controls settle two clocks ahead of the pos edge, stand a cycle
            nxt_rgo = rd_req;
            nxt_wgo = wr_req;
            nxt_addr = req_addr;
            nxt_d  = wr_word0;
            nxt_m  = wr_mask0_n;
            nxt_d1 = wr_word1;
            nxt_m1 = wr_mask1_n;
            nxt_taken = rd_req | wr_req;
            nxt_ph = dpb_pkg::DPB_HIGH;
         end
         dpb_pkg::DPB_HIGH: if (div_ff == `DPB_CLK_HALF - 4'h3) begin
            // second word changes two clocks clear of both input edges
            nxt_d   = d1_ff;
            nxt_m   = m1_ff;
            nxt_ph  = dpb_pkg::DPB_LOW;
         end
         dpb_pkg::DPB_LOW: if (div_ff == `DPB_CLK_HALF - 4'h1)
            nxt_ph = dpb_pkg::DPB_IDLE;
         default: nxt_ph = dpb_pkg::DPB_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_ff <= 4'h0;
         ph_ff  <= dpb_pkg::DPB_IDLE;
         rgo_ff <= 1'b0;
         wgo_ff <= 1'b0;
         addr_ff <= '0;
         d_ff <= '0;
         d1_ff <= '0;
         m_ff <= '1;
         m1_ff <= '1;
         taken_ff <= 1'b0;
         tie_ff <= 1'b0;
      end else if (clk_en) begin
         div_ff <= nxt_div;
         ph_ff  <= nxt_ph;
         rgo_ff <= nxt_rgo;
         wgo_ff <= nxt_wgo;
         addr_ff <= nxt_addr;
         d_ff <= nxt_d;
         d1_ff <= nxt_d1;
         m_ff <= nxt_m;
         m1_ff <= nxt_m1;
         taken_ff <= nxt_taken;
         tie_ff <= tie_out_clk;
      end
   end

   // read capture: take a word on each rising strobe edge while driven
   wire logic [2:0] q_raw = {pins.rd_beat_oe, pins.return_strobe_pos,
      pins.return_strobe_neg};
   wire logic q_edge = (q2_ff[1] & ~q3_ff[1]) | (q2_ff[0] & ~q3_ff[0]);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q1_ff <= 3'h1;
         q2_ff <= 3'h1;
         q3_ff <= 2'h1;
         qd1_ff <= '0;
         qd2_ff <= '0;
         vld_ff <= 1'b0;
         rw_ff  <= '0;
      end else if (clk_en) begin
         q1_ff <= q_raw;
         q2_ff <= q1_ff;
         q3_ff <= q2_ff[1:0];
         qd1_ff <= pins.rd_beat_out;
         qd2_ff <= qd1_ff;
         vld_ff <= q2_ff[2] & q_edge;
         if (q2_ff[2] && q_edge)
            rw_ff <= qd2_ff;
      end
   end

   assign pins.in_edge_pos      = k_hi;
   assign pins.in_edge_neg      = ~k_hi;
   assign pins.out_edge_pos     = tie_ff ? 1'b1 : k_hi;
   assign pins.out_edge_neg     = tie_ff ? 1'b1 : ~k_hi;
   assign pins.fetch_go_n       = ~rgo_ff;
   assign pins.store_go_n       = ~wgo_ff;
   assign pins.addr             = addr_ff;
   assign pins.wr_beat_in       = d_ff;
   assign pins.lane_mask_n      = m_ff;
   assign pins.phase_loop_off_n = ~loop_off;
   assign req_taken = taken_ff;
   assign rd_valid  = vld_ff;
   assign rd_word   = rw_ff;
endmodule : dpb_ctrl

// ### verification/dpb_link_checker.sv
// Purpose: protocol watch on the link pins between the two ends
// Assumes: link clocks are clk divided by 8, half period of 4
// Notes:   data pins are left to the bench comparisons
`timescale 1ns/1ns
module dpb_link_checker (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic in_edge_pos,
   input wire logic in_edge_neg,
   input wire logic out_edge_pos,
   input wire logic out_edge_neg,
   input wire logic fetch_go_n,
   input wire logic store_go_n,
   input wire logic rd_beat_oe,
   input wire logic return_strobe_pos,
   input wire logic return_strobe_neg
);
   logic [5:0] since_rd_ff;
   logic [5:0] nxt_since_rd;
   // saturates so a long idle spell never wraps into a false window
   always_comb begin
      nxt_since_rd = since_rd_ff;
      if (!fetch_go_n) begin
         nxt_since_rd = 6'h00;
      end else if (since_rd_ff != 6'h3F) begin
         nxt_since_rd = since_rd_ff + 6'h01;
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         since_rd_ff <= 6'h3F;
      end else begin
         since_rd_ff <= nxt_since_rd;
      end
   end
   default clocking cb @(posedge clk); endclocking
   // a frozen clock enable stalls every link timing, so checks pause too
   default disable iff (!reset_n || !clk_en);
   a_in_pair_inverse: assert property (in_edge_neg == !in_edge_pos)
      else $error("input clock pair not complementary");
   a_out_never_low: assert property (out_edge_pos || out_edge_neg)
      else $error("output clock pair both low");
   a_out_tie_static: assert property ($past(reset_n) && out_edge_pos
      && out_edge_neg |=> out_edge_pos && out_edge_neg)
      else $error("tied output clocks toggled");
   a_link_half_period: assert property ($rose(in_edge_pos) |->
      in_edge_pos [*4] ##1 !in_edge_pos)
      else $error("input clock high phase not four cycles");
   a_strobe_runs: assert property (1'b1 |->
      ##[1:20] $changed(return_strobe_pos))
      else $error("echo strobe stopped");
   a_strobe_pair: assert property (return_strobe_neg == !return_strobe_pos)
      else $error("echo strobe pair not complementary");
   a_fetch_stands: assert property ($fell(fetch_go_n) |-> !fetch_go_n [*8])
      else $error("read select shorter than a link cycle");
   a_store_stands: assert property ($fell(store_go_n) |-> !store_go_n [*8])
      else $error("write select shorter than a link cycle");
   a_read_answers: assert property ($fell(fetch_go_n) |-> ##[4:40] rd_beat_oe)
      else $error("read data never driven");
   a_no_stray_read: assert property (rd_beat_oe |-> since_rd_ff < 6'h28)
      else $error("read bus driven without a read");
   a_go_at_pos: assert property ($changed(fetch_go_n) |->
      ##2 $rose(in_edge_pos))
      else $error("read select not set up before input clock");
endmodule : dpb_link_checker

// ### verification/dual_port_burst2_sram_interface_test.sv
// Purpose: end-to-end bench, controller facing device over the link
// Assumes: default build; low data bits carry the word address
// Notes:   words carry their address so a misplaced word shows at once
`timescale 1ns/1ns
`include "dpb_defs.svh"
module dual_port_burst2_sram_interface_test;
   localparam int W = `DPB_WIDTH_DEF;
   localparam int A = `DPB_ADDR_DEF;
   localparam int L = `DPB_LANE_DEF;
   logic         clk, reset_n, clk_en, tie_out_clk, loop_off;
   logic         rd_req, wr_req, req_taken, rd_valid, loop_bypass;
   logic [A-1:0] req_addr, ra;
   logic [W-1:0] wr_word0, wr_word1, rd_word;
   logic [L-1:0] wr_mask0_n, wr_mask1_n;
   logic [W-1:0] mem [0:(1<<A)-1];
   logic [W-1:0] expq [$];
   logic [31:0]  seed;
   int           miscompares, n_tests, cycles, i;
   dpb_if #(.W(W), .A(A), .L(L)) dpb_if_i ();
   dpb_ctrl #(.W(W), .A(A), .L(L)) dpb_ctrl_i (.clk(clk), .reset_n(reset_n),
      .clk_en(clk_en), .pins(dpb_if_i.ctrl), .tie_out_clk(tie_out_clk),
      .loop_off(loop_off), .rd_req(rd_req), .wr_req(wr_req),
      .req_addr(req_addr), .wr_word0(wr_word0), .wr_word1(wr_word1),
      .wr_mask0_n(wr_mask0_n), .wr_mask1_n(wr_mask1_n),
      .req_taken(req_taken), .rd_valid(rd_valid), .rd_word(rd_word));
   dpb_device #(.W(W), .A(A), .L(L)) dpb_device_i (.clk(clk),
      .reset_n(reset_n), .clk_en(clk_en), .pins(dpb_if_i.dev),
      .loop_bypass(loop_bypass));
   dpb_link_checker dpb_link_checker_i (.clk(clk), .reset_n(reset_n),
      .clk_en(clk_en),
      .in_edge_pos(dpb_if_i.in_edge_pos), .in_edge_neg(dpb_if_i.in_edge_neg),
      .out_edge_pos(dpb_if_i.out_edge_pos),
      .out_edge_neg(dpb_if_i.out_edge_neg),
      .fetch_go_n(dpb_if_i.fetch_go_n), .store_go_n(dpb_if_i.store_go_n),
      .rd_beat_oe(dpb_if_i.rd_beat_oe),
      .return_strobe_pos(dpb_if_i.return_strobe_pos),
      .return_strobe_neg(dpb_if_i.return_strobe_neg));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] r;
      r = s ^ (s << 13);
      r = r ^ (r >> 17);
      r = r ^ (r << 5);
      return r;
   endfunction : xs
   function automatic logic [W-1:0] merge(input logic [W-1:0] old,
      input logic [W-1:0] nw, input logic [L-1:0] m_n);
      logic [W-1:0] r;
      for (int b = 0; b < W; b++) r[b] = m_n[b / (W / L)] ? old[b] : nw[b];
      return r;
   endfunction : merge
   task automatic check(input logic [W-1:0] seen, input logic [W-1:0] want);
      n_tests++;
      if (seen !== want) begin
         miscompares++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check
   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results
   task automatic do_reset(input logic tie);
      reset_n <= 1'b0;
      tie_out_clk <= tie;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
   endtask : do_reset
   // words carry the address in the low bits; random bits above
   task automatic req(input logic rd, input logic wr, input logic [A-1:0] a,
      input logic [L-1:0] m0, input logic [L-1:0] m1);
      logic [W-1:0] d0;
      logic [W-1:0] d1;
      int           k;
      seed = xs(seed);
      d0 = {seed[W-A-1:0], a};
      seed = xs(seed);
      d1 = {seed[W-A-1:0], a + 1'b1};
      // a read sees a write taken on the same edge: it lands first
      if (wr) begin
         mem[a] = merge(mem[a], d0, m0);
         mem[a + 1'b1] = merge(mem[a + 1'b1], d1, m1);
      end
      if (rd) begin
         expq.push_back(mem[a]);
         expq.push_back(mem[a + 1'b1]);
      end
      @(posedge clk);
      rd_req <= rd;
      wr_req <= wr;
      req_addr <= a;
      wr_word0 <= d0;
      wr_word1 <= d1;
      wr_mask0_n <= m0;
      wr_mask1_n <= m1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (req_taken !== 1'b1 && k < 40);
      if (k >= 40) miscompares++;
      rd_req <= 1'b0;
      wr_req <= 1'b0;
   endtask : req
   task automatic drain(input string name);
      int k;
      k = 0;
      while (expq.size() != 0 && k < 400) begin
         @(posedge clk);
         k++;
      end
      if (expq.size() != 0) miscompares++;
      $display("test %s done, mismatches so far %0d", name, miscompares);
   endtask : drain
   task automatic read_all;
      for (int j = 0; j < 8; j++) req(1'b1, 1'b0, A'(2 * j), 2'h0, 2'h0);
   endtask : read_all
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         results();
      end
   end
   always @(posedge clk) begin
      if (rd_valid === 1'b1) begin
         if (expq.size() == 0) begin
            check(rd_word, ~rd_word);
         end else begin
            check(rd_word, expq.pop_front());
         end
      end
   end
   initial begin
      {reset_n, rd_req, wr_req, loop_off, tie_out_clk} = 5'h00;
      {clk_en, req_addr, wr_word0, wr_word1} = '0;
      clk_en = 1'b1;
      {wr_mask0_n, wr_mask1_n} = '1;
      {miscompares, n_tests, cycles} = '0;
      seed = 32'h18FB;
      do_reset(1'b0);
      for (i = 0; i < 8; i++) req(1'b0, 1'b1, A'(2 * i), 2'h0, 2'h0);
      read_all();
      drain("full write");
      for (i = 0; i < 4; i++) req(1'b0, 1'b1, A'(2 * i), 2'h1, 2'h2);
      read_all();
      drain("lane masks");
      for (i = 0; i < 8; i++) req(1'b1, 1'b1, A'(2 * i), 2'h2, 2'h1);
      drain("concurrent");
      for (i = 0; i < 6; i++) begin
         ra = A'({seed[3:1], 1'b0});
         req(1'b0, 1'b1, ra, seed[9:8], seed[11:10]);
      end
      read_all();
      drain("random masks");
      do_reset(1'b1);
      read_all();
      drain("tied output clocks");
      loop_off <= 1'b1;
      repeat (8) @(posedge clk);
      check(W'(loop_bypass), W'(1'b1));
      loop_off <= 1'b0;
      clk_en <= 1'b0;
      repeat (16) @(posedge clk);
      clk_en <= 1'b1;
      repeat (8) @(posedge clk);
      check(W'(loop_bypass), W'(1'b0));
      drain("loop bypass");
      results();
   end
endmodule : dual_port_burst2_sram_interface_test
